//--- pclp_latch_bank.sv
// Configuration latch bank with serial loader, power-down sequencing and lock detect.
//
// Functional notes
// - Select bits 00 store into control word.
// - Select bits 01 store into reference word.
// - Request with sync clear powers down immediately.
// - Synchronous power-down waits second reference edge.
// - Chip enable low disables device at once.
// - Power-down resets counters, tri-states pump, clears lock.
// - Serial loading continues during power-down.
// - Gain bit selects pump current setting two.
// - Gain flag holds most recent write.
// - Mute keeps outputs off until lock.
// - Tri-state bit puts pump in high impedance.
// - Polarity bit one selects positive detector.
// - Counter reset bit holds dividers in reset.
// - Thirteen-bit feedback divide, three to 8191.
// - Fourteen-bit reference divide, band clock divider.
// - Two bits select antibacklash pulse width.
// - Lock after five or three good cycles.
// - Test flag zero means normal three-word operation.
// - Shift on serial clock, transfer on load.
`timescale 1ns/1ps
`default_nettype none
module pclp_latch_bank (
	// System clock and reset.
	input wire logic clk_sys,
	input wire logic rstn,
	// Three-wire serial link pins.
	input wire logic serial_clk,
	input wire logic serial_data,
	input wire logic load_enable,
	// Chip enable pin.
	input wire logic chip_enable,
	// Reference divider output and phase error indication from the loop.
	input wire logic ref_div_edge_in,
	input wire logic phase_error_small,
	// Decoded controls towards the analog loop.
	output logic powered_down,
	output logic counters_in_reset,
	output logic pump_tristate,
	output logic pump_polarity_positive,
	output logic [2:0] pump_current,
	output logic outputs_enabled,
	output logic ref_buffer_enable,
	output logic lock_detect,
	output logic [12:0] feedback_divide,
	output logic [13:0] reference_divide,
	output logic [1:0] antibacklash_width,
	output logic [1:0] band_clk_divide_select,
	output logic test_latch_active
);

	// ------------------------------------------------------------
	// Reset release and input synchronisers.
	// ------------------------------------------------------------
	// Reset is asserted at once and released only on a clock edge.
	logic [1:0] rst_sync_q;
	logic rst_n;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Each pin passes two flip-flops; the third stage only feeds edge detection.
	logic [4:0] pin_meta_q;
	logic [4:0] pin_sync_q;
	logic [4:0] pin_last_q;
	wire [4:0] pin_raw = {phase_error_small, ref_div_edge_in, chip_enable, load_enable, serial_clk};
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= 5'h0;
			pin_sync_q <= 5'h0;
			pin_last_q <= 5'h0;
		end else begin
			pin_meta_q <= pin_raw;
			pin_sync_q <= pin_meta_q;
			pin_last_q <= pin_sync_q;
		end
	end

	logic data_meta_q;
	logic data_sync_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			data_meta_q <= 1'b0;
			data_sync_q <= 1'b0;
		end else begin
			data_meta_q <= serial_data;
			data_sync_q <= data_meta_q;
		end
	end

	wire sclk_rise = pin_sync_q[0] & ~pin_last_q[0];
	wire load_rise = pin_sync_q[1] & ~pin_last_q[1];
	wire ce_level = pin_sync_q[2];
	wire ref_rise = pin_sync_q[3] & ~pin_last_q[3];
	wire phase_ok = pin_sync_q[4];

	// ------------------------------------------------------------
	// Serial input register and latch transfer.
	// ------------------------------------------------------------
	logic [23:0] shift_q;
	logic [23:0] shift_d;
	logic [23:0] control_q;
	logic [23:0] feedback_q;
	logic [23:0] reference_q;
	logic [23:0] test_q;
	logic gain_q;

	// Shifting keeps running in power-down.
	assign shift_d = sclk_rise ? {shift_q[22:0], data_sync_q} : shift_q;
	wire [1:0] word_sel = shift_q[1:0];
	wire wr_control = load_rise && (word_sel == pclp_pkg::SEL_CONTROL);
	wire wr_reference = load_rise && (word_sel == pclp_pkg::SEL_REFERENCE);
	wire wr_feedback = load_rise && (word_sel == pclp_pkg::SEL_FEEDBACK);
	wire wr_test = load_rise && (word_sel == pclp_pkg::SEL_TEST);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= 24'h000000;
		end else begin
			shift_q <= shift_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			control_q <= pclp_pkg::CONTROL_RESET;
		end else if (wr_control) begin
			control_q <= shift_q;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			feedback_q <= pclp_pkg::FEEDBACK_RESET;
		end else if (wr_feedback) begin
			feedback_q <= shift_q;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reference_q <= pclp_pkg::REFERENCE_RESET;
		end else if (wr_reference) begin
			reference_q <= shift_q;
		end
	end

	// The test word is kept but acts only while the test flag is also set.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			test_q <= 24'h000000;
		end else if (wr_test) begin
			test_q <= shift_q;
		end
	end

	// The gain flag follows whichever word carried it last.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gain_q <= 1'b0;
		end else if (wr_control) begin
			gain_q <= shift_q[pclp_pkg::CTL_GAIN];
		end else if (wr_feedback) begin
			gain_q <= shift_q[pclp_pkg::FB_GAIN];
		end
	end

	// ------------------------------------------------------------
	// Power-down sequencing.
	// ------------------------------------------------------------
	pclp_pkg::pclp_power_type pwr_q;
	pclp_pkg::pclp_power_type pwr_d;
	logic [1:0] ref_edges_q;
	logic [1:0] ref_edges_d;
	wire pd_request = control_q[pclp_pkg::CTL_PD_REQUEST];
	wire pd_sync = control_q[pclp_pkg::CTL_PD_SYNC];
	wire sync_done = ref_rise && (ref_edges_q == 2'(pclp_pkg::SYNC_PD_EDGES - 1));

	always_comb begin
		pwr_d = pwr_q;
		ref_edges_d = ref_edges_q;
		unique case (pwr_q)
			pclp_pkg::PWR_ON: begin
				ref_edges_d = 2'h0;
				if (pd_request && !pd_sync) begin
					pwr_d = pclp_pkg::PWR_DOWN;
				end else if (pd_request && pd_sync) begin
					pwr_d = pclp_pkg::PWR_WAIT;
				end
			end
			// Reference edges are counted only while waiting for the synchronous entry.
			pclp_pkg::PWR_WAIT: begin
				if (!pd_request) begin
					pwr_d = pclp_pkg::PWR_ON;
				end else if (!pd_sync) begin
					pwr_d = pclp_pkg::PWR_DOWN;
				end else if (sync_done) begin
					pwr_d = pclp_pkg::PWR_DOWN;
				end else if (ref_rise) begin
					ref_edges_d = ref_edges_q + 2'h1;
				end
			end
			pclp_pkg::PWR_DOWN: begin
				ref_edges_d = 2'h0;
				if (!pd_request) begin
					pwr_d = pclp_pkg::PWR_ON;
				end
			end
			default: begin
				pwr_d = pclp_pkg::PWR_DOWN;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pwr_q <= pclp_pkg::PWR_ON;
			ref_edges_q <= 2'h0;
		end else begin
			pwr_q <= pwr_d;
			ref_edges_q <= ref_edges_d;
		end
	end

	// Chip enable low overrides the programmed mode.
	wire down_now = (pwr_q == pclp_pkg::PWR_DOWN) || !ce_level;

	// ------------------------------------------------------------
	// Lock detect.
	// ------------------------------------------------------------
	logic [2:0] good_q;
	logic [2:0] good_d;
	wire [2:0] lock_need = reference_q[pclp_pkg::REF_LOCK_PRECISION] ?
		3'(pclp_pkg::LOCK_CYCLES_FINE) : 3'(pclp_pkg::LOCK_CYCLES_COARSE);
	wire counters_hold = down_now || control_q[pclp_pkg::CTL_COUNTER_RESET];

	// The count stops at its target so a change of precision cannot wrap it.
	always_comb begin
		good_d = good_q;
		if (counters_hold) begin
			good_d = 3'h0;
		end else if (ref_rise) begin
			if (!phase_ok) begin
				good_d = 3'h0;
			end else if (good_q < lock_need) begin
				good_d = good_q + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			good_q <= 3'h0;
		end else begin
			good_q <= good_d;
		end
	end

	// ------------------------------------------------------------
	// Next values of the decoded controls.
	// ------------------------------------------------------------
	wire [2:0] cur_one = control_q[pclp_pkg::CTL_CURRENT_ONE +: 3];
	wire [2:0] cur_two = control_q[pclp_pkg::CTL_CURRENT_TWO +: 3];
	wire mute_on = control_q[pclp_pkg::CTL_MUTE];
	// Lock and output enable share the counter's next value so they move together while mute is set.
	wire next_lock = good_d >= lock_need;
	wire lock_detect_d = next_lock && !counters_hold;
	wire outputs_enabled_d = !down_now && (!mute_on || next_lock);
	wire pump_tristate_d = down_now || control_q[pclp_pkg::CTL_TRISTATE];
	wire pump_polarity_d = control_q[pclp_pkg::CTL_POLARITY];
	wire [2:0] pump_current_d = gain_q ? cur_two : cur_one;
	wire [12:0] feedback_divide_d = feedback_q[pclp_pkg::FB_DIVIDE +: 13];
	wire [13:0] reference_divide_d = reference_q[pclp_pkg::REF_DIVIDE +: 14];
	wire [1:0] antibacklash_d = reference_q[pclp_pkg::REF_ANTIBACKLASH +: 2];
	wire [1:0] band_select_d = reference_q[pclp_pkg::REF_BAND_CLK +: 2];
	wire test_active_d = reference_q[pclp_pkg::REF_TEST_FLAG] && (test_q != 24'h000000);

	// ------------------------------------------------------------
	// Power and lock outputs.
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			powered_down <= 1'b1;
			counters_in_reset <= 1'b1;
			outputs_enabled <= 1'b0;
			ref_buffer_enable <= 1'b0;
			lock_detect <= 1'b0;
		end else begin
			powered_down <= down_now;
			counters_in_reset <= counters_hold;
			outputs_enabled <= outputs_enabled_d;
			ref_buffer_enable <= !down_now;
			lock_detect <= lock_detect_d;
		end
	end

	// ------------------------------------------------------------
	// Charge pump outputs.
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pump_tristate <= 1'b1;
			pump_polarity_positive <= 1'b0;
			pump_current <= 3'h0;
		end else begin
			pump_tristate <= pump_tristate_d;
			pump_polarity_positive <= pump_polarity_d;
			pump_current <= pump_current_d;
		end
	end

	// ------------------------------------------------------------
	// Divider, antibacklash and test outputs.
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			feedback_divide <= 13'h0000;
			reference_divide <= 14'h0000;
			antibacklash_width <= 2'h0;
			band_clk_divide_select <= 2'h0;
			test_latch_active <= 1'b0;
		end else begin
			feedback_divide <= feedback_divide_d;
			reference_divide <= reference_divide_d;
			antibacklash_width <= antibacklash_d;
			band_clk_divide_select <= band_select_d;
			test_latch_active <= test_active_d;
		end
	end

endmodule
`default_nettype wire

//--- pclp_pkg.sv
// Package with the latch map, field positions and timing constants of the configuration latch bank.
package pclp_pkg;
	localparam int WORD_BITS = 24;
	localparam logic [1:0] SEL_CONTROL = 2'h0;
	localparam logic [1:0] SEL_FEEDBACK = 2'h2;
	localparam logic [1:0] SEL_REFERENCE = 2'h1;
	localparam logic [1:0] SEL_TEST = 2'h3;
	localparam logic [23:0] CONTROL_RESET = 24'h000000;
	localparam logic [23:0] FEEDBACK_RESET = 24'h000000;
	localparam logic [23:0] REFERENCE_RESET = 24'h000000;
	localparam int CTL_COUNTER_RESET = 4;
	localparam int CTL_POLARITY = 8;
	localparam int CTL_TRISTATE = 9;
	localparam int CTL_GAIN = 10;
	localparam int CTL_MUTE = 11;
	localparam int CTL_CURRENT_ONE = 14;
	localparam int CTL_CURRENT_TWO = 17;
	localparam int CTL_PD_REQUEST = 20;
	localparam int CTL_PD_SYNC = 21;
	localparam int FB_DIVIDE = 8;
	localparam int FB_GAIN = 21;
	localparam int REF_DIVIDE = 2;
	localparam int REF_ANTIBACKLASH = 16;
	localparam int REF_LOCK_PRECISION = 18;
	localparam int REF_TEST_FLAG = 19;
	localparam int REF_BAND_CLK = 20;
	localparam int LOCK_CYCLES_FINE = 5;
	localparam int LOCK_CYCLES_COARSE = 3;
	localparam int SYNC_PD_EDGES = 2;
	typedef enum logic [2:0] {
		PWR_ON = 3'b001,
		PWR_WAIT = 3'b010,
		PWR_DOWN = 3'b100
	} pclp_power_type;
endpackage

//--- pclp_host.sv
// Behavioural controller that writes 24-bit words over the three-wire link.
`timescale 1ns/1ps
`default_nettype none
module pclp_host (
	// Pacing clock.
	input wire logic clk_sys,
	// Three-wire link.
	output logic serial_clk = 1'b0,
	output logic serial_data = 1'b0,
	output logic load_enable = 1'b0
);
	// Sends the word first bit first and pulses load; the link clock rests low between words.
	task send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			serial_data <= w[i];
			repeat (4) @(posedge clk_sys);
			serial_clk <= 1'b1;
			repeat (4) @(posedge clk_sys);
			serial_clk <= 1'b0;
		end
		serial_data <= ~w[0];
		repeat (4) @(posedge clk_sys);
		load_enable <= 1'b1;
		repeat (4) @(posedge clk_sys);
		load_enable <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

//--- pclp_checker.sv
// Checker of the latch bank outputs against their causes at the pins.
`timescale 1ns/1ps
`default_nettype none
module pclp_checker (
	// Clock, reset and pins.
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic load_enable,
	input wire logic chip_enable,
	input wire logic phase_error_small,
	// Decoded controls.
	input wire logic powered_down,
	input wire logic counters_in_reset,
	input wire logic pump_tristate,
	input wire logic pump_polarity_positive,
	input wire logic outputs_enabled,
	input wire logic ref_buffer_enable,
	input wire logic lock_detect,
	input wire logic [2:0] pump_current,
	input wire logic [12:0] feedback_divide,
	input wire logic [13:0] reference_divide,
	input wire logic [1:0] antibacklash_width,
	input wire logic [1:0] band_clk_divide_select
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property p_pd_pump; powered_down |-> pump_tristate && counters_in_reset; endproperty
	a_pd_pump: assert property (p_pd_pump) else $error("pump live in power-down");
	property p_pd_quiet; powered_down && $past(powered_down) |-> !outputs_enabled && !lock_detect; endproperty
	a_pd_quiet: assert property (p_pd_quiet) else $error("outputs or lock live in power-down");
	property p_buf; $stable(powered_down) |-> ref_buffer_enable == !powered_down; endproperty
	a_buf: assert property (p_buf) else $error("reference buffer wrong");
	property p_ce_off; $fell(chip_enable) |-> ##[1:6] powered_down; endproperty
	a_ce_off: assert property (p_ce_off) else $error("chip enable low ignored");
	property p_ce_on; $fell(powered_down) |-> chip_enable; endproperty
	a_ce_on: assert property (p_ce_on) else $error("power-up with chip enable low");
	property p_lock; $rose(lock_detect) |-> !powered_down && $past(phase_error_small, 2); endproperty
	a_lock: assert property (p_lock) else $error("lock without good phase");
	property p_hold; !load_enable [*8] |-> $stable({feedback_divide, reference_divide, antibacklash_width}); endproperty
	a_hold: assert property (p_hold) else $error("divider changed without load");
	property p_pump; !load_enable [*8] |-> $stable({pump_current, pump_polarity_positive}); endproperty
	a_pump: assert property (p_pump) else $error("pump setting changed without load");
endmodule
`default_nettype wire

//--- pclp_latch_bank_bench.sv
// Scripted testbench of the configuration latch bank.
`timescale 1ns/1ps
`default_nettype none
module pclp_latch_bank_bench;
	localparam int SETTLE = 60000;
	logic clk_sys = 1'b0, rstn = 1'b0, chip_enable = 1'b0, ref_div_edge_in = 1'b0, phase_error_small = 1'b0;
	logic serial_clk, serial_data, load_enable, powered_down, counters_in_reset, pump_tristate;
	logic pump_polarity_positive, outputs_enabled, ref_buffer_enable, lock_detect, test_latch_active;
	logic [2:0] pump_current;
	logic [12:0] feedback_divide;
	logic [13:0] reference_divide;
	logic [1:0] antibacklash_width, band_clk_divide_select;
	int err_total = 0;
	int n_tests = 0;
	always #5 clk_sys = ~clk_sys;
	pclp_latch_bank u_pclp_latch_bank (.*);
	pclp_host u_pclp_host (.*);
	task report_and_stop;
		if (err_total == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task wr(input logic [23:0] w);
		u_pclp_host.send(w);
	endtask
	task pulse(input int n);
		repeat (n) begin
			ref_div_edge_in <= 1'b1;
			wt(6);
			ref_div_edge_in <= 1'b0;
			wt(6);
		end
	endtask
	task wait_pd(input logic exp);
		for (int i = 0; i < 12 && powered_down !== exp; i++) wt(1);
		chk("pd", {15'h0, exp}, {15'h0, powered_down});
		if (powered_down !== exp) report_and_stop();
	endtask
	task t_load;
		wr(24'h32FFFD);
		wr(24'h054100);
		wt(SETTLE);
		wr(24'h200302);
		chk("ref", 16'h3FFF, {2'h0, reference_divide});
		chk("abl", 16'h2, {14'h0, antibacklash_width});
		chk("band", 16'h3, {14'h0, band_clk_divide_select});
		chk("fb", 16'h3, {3'h0, feedback_divide});
		chk("cur", 16'h2, {13'h0, pump_current});
		chk("pol", 16'h1, {15'h0, pump_polarity_positive});
		chk("tst", 16'h0, {15'h0, test_latch_active});
		wr(24'h054100);
		chk("cur", 16'h5, {13'h0, pump_current});
		wr(24'h1FFF02);
		chk("fb", 16'h1FFF, {3'h0, feedback_divide});
	endtask
	task t_pwr;
		wr(24'h100000);
		chk("pump", 16'h3, {14'h0, pump_tristate, counters_in_reset});
		chk("buf", 16'h0, {15'h0, ref_buffer_enable});
		wait_pd(1'b1);
		wr(24'h30001D);
		chk("ref", 16'h7, {2'h0, reference_divide});
		wr(24'h000210);
		wait_pd(1'b0);
		chk("pump", 16'h3, {14'h0, pump_tristate, counters_in_reset});
		chk("pol", 16'h0, {15'h0, pump_polarity_positive});
		wr(24'h300000);
		pulse(1);
		chk("pd", 16'h0, {15'h0, powered_down});
		pulse(1);
		wait_pd(1'b1);
		wr(24'h000000);
		wait_pd(1'b0);
		chip_enable <= 1'b0;
		wait_pd(1'b1);
		chip_enable <= 1'b1;
		wait_pd(1'b0);
	endtask
	task t_lock;
		wr(24'h000800);
		phase_error_small <= 1'b1;
		pulse(2);
		chk("lock", 16'h0, {14'h0, lock_detect, outputs_enabled});
		pulse(1);
		chk("lock", 16'h3, {14'h0, lock_detect, outputs_enabled});
		wr(24'h100800);
		chk("lock", 16'h0, {14'h0, lock_detect, outputs_enabled});
	endtask
	task t_fine;
		wr(24'h34001D);
		wr(24'h000800);
		pulse(4);
		chk("lock", 16'h0, {14'h0, lock_detect, outputs_enabled});
		pulse(1);
		chk("lock", 16'h3, {14'h0, lock_detect, outputs_enabled});
		wr(24'h30001D);
		pulse(3);
		chk("lock", 16'h3, {14'h0, lock_detect, outputs_enabled});
		phase_error_small <= 1'b0;
		pulse(1);
		chk("lock", 16'h0, {14'h0, lock_detect, outputs_enabled});
	endtask
	initial begin
		wt(4);
		rstn <= 1'b1;
		chip_enable <= 1'b1;
		wt(6);
		t_load();
		t_pwr();
		t_lock();
		t_fine();
		report_and_stop();
	end
	initial begin
		wt(90000);
		err_total++;
		report_and_stop();
	end
endmodule
bind pclp_latch_bank pclp_checker u_pclp_checker (.*);
`default_nettype wire
